// File: dv/dtc_pin_model.sv
`timescale 1ns/100ps
module dtc_pin_model (
  // Core clock
  input wire logic clock,
  // Pins
  output logic t0_count_pin,
  output logic t1_count_pin,
  output logic ext_pin_a,
  output logic ext_pin_b
);
  // Pins rest high on their pull-ups
  initial begin
    t0_count_pin = 1'b1;
    t1_count_pin = 1'b1;
    ext_pin_a = 1'b1;
    ext_pin_b = 1'b1;
  end
  // Entered at a falling edge; four cycles each level so the synchroniser sees every edge
  task automatic pulse(input logic ch, input int n);
    repeat (n) begin
      if (ch) t1_count_pin = 1'b0;
      else t0_count_pin = 1'b0;
      repeat (4) @(negedge clock);
      if (ch) t1_count_pin = 1'b1;
      else t0_count_pin = 1'b1;
      repeat (4) @(negedge clock);
    end
  endtask
  task automatic set_ext(input logic a, input logic b);
    ext_pin_a = a;
    ext_pin_b = b;
  endtask
endmodule

// File: dv/dtc_timers_sva.sv
`timescale 1ns/100ps
module dtc_timers_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Pins and flags
  input wire logic ext_pin_a,
  input wire logic ext_pin_b,
  input wire logic t0_overflow_flag,
  input wire logic t1_overflow_flag,
  input wire logic ext_ext_pin_a_detect_flag,
  input wire logic ext_ext_pin_b_detect_flag
);
  logic it0_r;
  logic it1_r;
  wire tctl_wr = sfr_wr && sfr_addr == dtc_pkg::ADDR_TCTL;
  // Type bits change only by software, so a write mirror is exact
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      it0_r <= 1'b0;
      it1_r <= 1'b0;
    end else if (tctl_wr) begin
      it0_r <= sfr_wdata[0];
      it1_r <= sfr_wdata[2];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_unmapped_read_ones: assert property (sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8E) |=> sfr_rdata == 8'hFF)
    else $error("unmapped read not all ones");
  a_clkctl_spare_ones: assert property (sfr_rd && sfr_addr == dtc_pkg::ADDR_CLKCTL |=> sfr_rdata[7:5] == 3'h7 && sfr_rdata[2:0] == 3'h7)
    else $error("absent clock control bits not one");
  a_tf0_soft_set: assert property (tctl_wr && sfr_wdata[5] |=> t0_overflow_flag)
    else $error("timer 0 flag not set by write");
  a_tf1_soft_set: assert property (tctl_wr && sfr_wdata[7] |=> t1_overflow_flag)
    else $error("timer 1 flag not set by write");
  a_tctl_read_flags: assert property (sfr_rd && sfr_addr == dtc_pkg::ADDR_TCTL |=> sfr_rdata[7] == $past(t1_overflow_flag) && sfr_rdata[5] == $past(t0_overflow_flag) && sfr_rdata[3] == $past(ext_ext_pin_b_detect_flag) && sfr_rdata[1] == $past(ext_ext_pin_a_detect_flag) && sfr_rdata[2] == $past(it1_r) && sfr_rdata[0] == $past(it0_r))
    else $error("timer control read mismatch");
  a_tmode_readback: assert property (sfr_wr && sfr_addr == dtc_pkg::ADDR_TMODE ##1 sfr_rd && sfr_addr == dtc_pkg::ADDR_TMODE |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("mode register readback mismatch");
  a_ie0_level_follow: assert property ((!it0_r && $stable(ext_pin_a))[*5] |-> ext_ext_pin_a_detect_flag == !ext_pin_a)
    else $error("level flag 0 not following pin");
  a_ie1_level_follow: assert property ((!it1_r && $stable(ext_pin_b))[*5] |-> ext_ext_pin_b_detect_flag == !ext_pin_b)
    else $error("level flag 1 not following pin");
  a_ie0_edge_catch: assert property (it0_r && $stable(it0_r) && $fell(ext_pin_a) |-> ##[1:4] ext_ext_pin_a_detect_flag)
    else $error("falling edge 0 missed");
endmodule

// File: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clock;
  logic rst_n;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [7:0] got;
  logic [7:0] held;
  logic [3:0] acks;
  logic t0_count_pin, t1_count_pin, ext_pin_a, ext_pin_b;
  logic t0_overflow_flag, t1_overflow_flag, ext_ext_pin_a_detect_flag, ext_ext_pin_b_detect_flag;
  int err_total;
  int total_checks;
  int n;
  dtc_timers i_dtc_timers (.clock, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .t0_vec_ack(acks[3]), .t1_vec_ack(acks[2]), .x0_vec_ack(acks[1]), .x1_vec_ack(acks[0]),
    .t0_count_pin, .t1_count_pin, .ext_pin_a, .ext_pin_b, .t0_overflow_flag, .t1_overflow_flag,
    .ext_ext_pin_a_detect_flag, .ext_ext_pin_b_detect_flag);
  dtc_pin_model i_dtc_pin_model (.clock, .t0_count_pin, .t1_count_pin, .ext_pin_a, .ext_pin_b);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Entered at a falling edge; r adds a read in the cycle after the first strobe
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic r);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge clock);
    sfr_wr = 1'b0;
    sfr_rd = r;
    @(negedge clock);
    sfr_rd = 1'b0;
    got = sfr_rdata;
    @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, 1'b1);
    chk(got, e);
  endtask
  task automatic ack(input logic [3:0] m);
    acks = m;
    @(negedge clock);
    acks = 4'h0;
    @(negedge clock);
  endtask
  task automatic ovf_time(input logic ch, input logic fast);
    int div;
    div = fast ? 4 : 12;
    wr(8'h8E, 8'(fast) << (3 + ch));
    wr(8'h8A + ch, 8'hFE);
    wr(8'h8C + ch, 8'hFF);
    wr(8'h88, 8'h10 << (2 * ch));
    n = 0;
    while ((ch ? t1_overflow_flag : t0_overflow_flag) !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    chk(8'(n >= div - 1 && n <= 2 * div - 2), 8'h01);
    wr(8'h88, 8'h20 << (2 * ch));
    rd(8'h8C + ch, 8'h00);
    rd(8'h8A + ch, 8'h00);
    ack(ch ? 4'h4 : 4'h8);
    chk(8'(ch ? t1_overflow_flag : t0_overflow_flag), 8'h00);
  endtask
  task automatic cnt(input logic ch, input logic [7:0] tm, input logic run, input logic [7:0] tl,
                     input logic [7:0] th, input logic pa, input int np, input logic [7:0] etl,
                     input logic [7:0] eth);
    wr(8'h89, tm);
    wr(8'h8A + ch, tl);
    wr(8'h8C + ch, th);
    i_dtc_pin_model.set_ext(pa, 1'b1);
    wr(8'h88, 8'(run) << (4 + 2 * ch));
    i_dtc_pin_model.pulse(ch, np);
    repeat (4) @(negedge clock);
    rd(8'h8A + ch, etl);
    rd(8'h8C + ch, eth);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200us;
    err_total++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    acks = 4'h0;
    err_total = 0;
    total_checks = 0;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    rd(8'h88, 8'h00);
    rd(8'h89, 8'h00);
    rd(8'h8D, 8'h00);
    wr(8'h87, 8'h00);
    rd(8'h87, 8'hFF);
    rd(8'h8F, 8'hFF);
    rd(8'h8E, 8'hE7);
    acc(1'b1, 8'h89, 8'h11, 1'b1);
    chk(got, 8'h11);
    for (int c = 0; c < 2; c++) begin
      ovf_time(c[0], 1'b1);
      ovf_time(c[0], 1'b0);
      rd(8'h8A + c[0], 8'h00);
      held = got;
      repeat (30) @(negedge clock);
      rd(8'h8A + c[0], held);
    end
    cnt(1'b0, 8'h06, 1'b1, 8'hFE, 8'hF0, 1'b1, 3, 8'hF1, 8'hF0);
    cnt(1'b0, 8'h04, 1'b1, 8'hFE, 8'h00, 1'b1, 3, 8'hE1, 8'h01);
    cnt(1'b0, 8'h05, 1'b1, 8'hFF, 8'h12, 1'b1, 2, 8'h01, 8'h13);
    cnt(1'b0, 8'h0D, 1'b1, 8'h10, 8'h00, 1'b0, 3, 8'h10, 8'h00);
    cnt(1'b0, 8'h0D, 1'b1, 8'h10, 8'h00, 1'b1, 3, 8'h13, 8'h00);
    cnt(1'b0, 8'h05, 1'b0, 8'h10, 8'h00, 1'b1, 3, 8'h10, 8'h00);
    cnt(1'b1, 8'h50, 1'b1, 8'h05, 8'h00, 1'b1, 3, 8'h08, 8'h00);
    cnt(1'b1, 8'h50, 1'b0, 8'h05, 8'h00, 1'b1, 3, 8'h05, 8'h00);
    cnt(1'b1, 8'h70, 1'b1, 8'h05, 8'h00, 1'b1, 3, 8'h05, 8'h00);
    // Split timer 0: low byte wraps at 8 bits, high byte idle without timer 1 run
    cnt(1'b0, 8'h07, 1'b1, 8'hFE, 8'h30, 1'b1, 3, 8'h01, 8'h30);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h40);
    repeat (30) @(negedge clock);
    chk(8'(t1_overflow_flag), 8'h01);
    rd(8'h8A, 8'h01);
    wr(8'h88, 8'h05);
    i_dtc_pin_model.set_ext(1'b0, 1'b0);
    repeat (6) @(negedge clock);
    chk(8'({ext_ext_pin_a_detect_flag, ext_ext_pin_b_detect_flag}), 8'h03);
    i_dtc_pin_model.set_ext(1'b1, 1'b1);
    repeat (6) @(negedge clock);
    chk(8'({ext_ext_pin_a_detect_flag, ext_ext_pin_b_detect_flag}), 8'h03);
    ack(4'h3);
    chk(8'({ext_ext_pin_a_detect_flag, ext_ext_pin_b_detect_flag}), 8'h00);
    wr(8'h88, 8'h00);
    i_dtc_pin_model.set_ext(1'b0, 1'b0);
    repeat (6) @(negedge clock);
    ack(4'h3);
    chk(8'({ext_ext_pin_a_detect_flag, ext_ext_pin_b_detect_flag}), 8'h03);
    i_dtc_pin_model.set_ext(1'b1, 1'b1);
    repeat (6) @(negedge clock);
    chk(8'({ext_ext_pin_a_detect_flag, ext_ext_pin_b_detect_flag}), 8'h00);
    wr(8'h88, 8'hA0);
    rd(8'h88, 8'hA0);
    report_and_stop();
  end
endmodule
bind dtc_timers dtc_timers_sva i_dtc_timers_sva (.clock, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .ext_pin_a, .ext_pin_b, .t0_overflow_flag, .t1_overflow_flag, .ext_ext_pin_a_detect_flag,
  .ext_ext_pin_b_detect_flag);

// File: rtl/dtc_pkg.sv
package dtc_pkg;

  // Byte addresses of the register port
  localparam logic [7:0] ADDR_TCTL = 8'h88;
  localparam logic [7:0] ADDR_TMODE = 8'h89;
  localparam logic [7:0] ADDR_T0_LO = 8'h8A;
  localparam logic [7:0] ADDR_T1_LO = 8'h8B;
  localparam logic [7:0] ADDR_T0_HI = 8'h8C;
  localparam logic [7:0] ADDR_T1_HI = 8'h8D;
  localparam logic [7:0] ADDR_CLKCTL = 8'h8E;

  // Value seen for absent registers and absent bits
  localparam logic [7:0] UNIMPL_READ = 8'hFF;

  // Timer control bit positions for channel 0; channel 1 sits CH_STRIDE higher
  localparam int BIT_X0_TYPE = 0;
  localparam int BIT_X0_FLAG = 1;
  localparam int BIT_T0_RUN = 4;
  localparam int BIT_T0_OVF = 5;
  localparam int CH_STRIDE = 2;

  // Clock control: timer 0 divide select, timer 1 one bit above
  localparam int BIT_T0_DIV = 3;

  // Timer mode register: timer 0 in the low nibble, timer 1 in the high nibble
  localparam int TMODE_FIELD_W = 4;

  // Reset values
  localparam logic [7:0] RST_TCTL = 8'h00;
  localparam logic [7:0] RST_TMODE = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [1:0] RST_DIVSEL = 2'h0;
  localparam logic [7:0] RST_RDATA = 8'hFF;

  // Mode select encodings
  localparam logic [1:0] MODE_PRESCALE = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // Prescaled counter width in the low byte
  localparam int PRESCALE_BITS = 5;
  localparam logic [4:0] PRESCALE_MAX = 5'h1F;

  // Internal count clock dividers, in core clocks per count
  localparam int DIV_FAST = 4;
  localparam int DIV_SLOW = 12;
  localparam int DIV_W = 4;
  localparam logic [3:0] DIV_LAST = 4'(DIV_SLOW - 1);
  localparam logic [3:0] DIV_FAST_MASK = 4'(DIV_FAST - 1);

  typedef struct packed {
    logic gate;
    logic ct;
    logic [1:0] mode;
  } dtc_tmode_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf;
  } dtc_cnt_t;

endpackage

// File: rtl/dtc_timers.sv
`timescale 1ns/100ps
// Behaviour
// - Absent registers and absent bits read back as all ones.
// - Timer 1 overflow flag sets on overflow, clears on vectoring, software writable.
// - Timer 0 overflow flag sets on overflow, clears on vectoring, software writable.
// - Timer 1 counts only while its run bit is one.
// - Timer 0 counts only while its run bit is one; its mode 11 high byte uses the timer 1 run bit.
// - External interrupt 1 flag: edge sets, vector clears; level mode follows pin.
// - External interrupt 0 flag behaves the same way as interrupt 1.
// - Each external interrupt has a type bit choosing edge or level detection.
// - Gate bit set: timer runs only while its interrupt pin is high and run set.
// - Source bit clear counts internal clock; set counts falling edges of count pin.
// - Mode 00 is an 8-bit counter behind a 5-bit prescaler.
// - Mode 01 is a full 16-bit counter.
// - Mode 10 counts the low byte and reloads it from the high byte.
// - Timer 0 mode 11: low byte uses timer 0 controls, high byte timer 1 run.
// - Timer 1 in mode 11 stops and holds its value.
// - Timer 0 divide select picks divide by 4 when set, 12 when clear.
// - Timer 1 divide select picks divide by 4 when set, 12 when clear.
module dtc_timers (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Vectoring acknowledges from the interrupt controller
  input wire logic t0_vec_ack,
  input wire logic t1_vec_ack,
  input wire logic x0_vec_ack,
  input wire logic x1_vec_ack,
  // External pins
  input wire logic t0_count_pin,
  input wire logic t1_count_pin,
  input wire logic ext_pin_a,
  input wire logic ext_pin_b,
  // Flags to the interrupt controller
  output logic t0_overflow_flag,
  output logic t1_overflow_flag,
  output logic ext_ext_pin_a_detect_flag,
  output logic ext_ext_pin_b_detect_flag
);

  // Pin order: count pin 0, count pin 1, interrupt pin a, interrupt pin b
  localparam int NPINS = 4;
  localparam int EXT_BASE = 2;

  logic [NPINS-1:0] pin_meta_r;
  logic [NPINS-1:0] pin_sync_r;
  logic [NPINS-1:0] pin_prev_r;
  logic [NPINS-1:0] pin_fall;

  logic [1:0] tr_r;
  logic [1:0] it_r;
  logic [1:0] tf_r;
  logic [1:0] ie_r;
  logic [1:0] tm_r;
  logic [7:0] tmode_r;
  logic [7:0] tl_r [2];
  logic [7:0] th_r [2];
  logic [dtc_pkg::DIV_W-1:0] div_r;
  logic [7:0] rdata_r;

  dtc_pkg::dtc_tmode_t tmode [2];
  dtc_pkg::dtc_cnt_t cnt [2];
  logic [1:0] sel_tick;
  logic [1:0] src_evt;
  logic [1:0] run_ok;
  logic [1:0] inc;
  logic [1:0] ovf_set;
  logic [1:0] vec_ack;
  logic [1:0] ext_ack;
  logic tick_fast;
  logic tick_slow;
  logic t0_split;
  logic t0_hi_inc;
  logic t0_hi_ovf;
  logic wr_tctl;
  logic [7:0] rdata_nxt;

  assign vec_ack = {t1_vec_ack, t0_vec_ack};
  assign ext_ack = {x1_vec_ack, x0_vec_ack};
  assign wr_tctl = sfr_wr && (sfr_addr == dtc_pkg::ADDR_TCTL);

  // Mode register nibbles, timer 0 low and timer 1 high
  assign tmode[0] = tmode_r[dtc_pkg::TMODE_FIELD_W-1:0];
  assign tmode[1] = tmode_r[2*dtc_pkg::TMODE_FIELD_W-1:dtc_pkg::TMODE_FIELD_W];
  assign t0_split = (tmode[0].mode == dtc_pkg::MODE_SPLIT);

  // Two-stage synchronisers; edges use only the settled stage and its delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= '1;
      pin_sync_r <= '1;
      pin_prev_r <= '1;
    end else begin
      pin_meta_r <= {ext_pin_b, ext_pin_a, t1_count_pin, t0_count_pin};
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  assign pin_fall = pin_prev_r & ~pin_sync_r;

  // Shared divider: fast tick every 4 clocks, slow tick every 12
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (div_r == dtc_pkg::DIV_LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  assign tick_fast = ((div_r & dtc_pkg::DIV_FAST_MASK) == dtc_pkg::DIV_FAST_MASK);
  assign tick_slow = (div_r == dtc_pkg::DIV_LAST);

  // One count step of a timer in the given mode
  function automatic dtc_pkg::dtc_cnt_t step(input logic [1:0] mode, input logic [7:0] lo,
                                             input logic [7:0] hi, input logic en);
    dtc_pkg::dtc_cnt_t r;
    r.lo = lo;
    r.hi = hi;
    r.ovf = 1'b0;
    if (en) begin
      unique case (mode)
        dtc_pkg::MODE_PRESCALE: begin
          // Upper three bits of the low byte are left alone
          if (lo[dtc_pkg::PRESCALE_BITS-1:0] == dtc_pkg::PRESCALE_MAX) begin
            r.lo[dtc_pkg::PRESCALE_BITS-1:0] = '0;
            r.hi = hi + 8'h01;
            r.ovf = (hi == 8'hFF);
          end else begin
            r.lo[dtc_pkg::PRESCALE_BITS-1:0] = lo[dtc_pkg::PRESCALE_BITS-1:0] + 5'h01;
          end
        end
        dtc_pkg::MODE_16BIT: begin
          {r.hi, r.lo} = {hi, lo} + 16'h0001;
          r.ovf = ({hi, lo} == 16'hFFFF);
        end
        dtc_pkg::MODE_RELOAD: begin
          r.lo = (lo == 8'hFF) ? hi : lo + 8'h01;
          r.ovf = (lo == 8'hFF);
        end
        dtc_pkg::MODE_SPLIT: begin
          r.lo = lo + 8'h01;
          r.ovf = (lo == 8'hFF);
        end
      endcase
    end
    return r;
  endfunction

  // High byte of timer 0 in split mode: internal clock, timer 1 run bit only
  assign t0_hi_inc = t0_split && tr_r[1] && sel_tick[0];
  assign t0_hi_ovf = t0_hi_inc && (th_r[0] == 8'hFF);

  generate
    for (genvar i = 0; i < 2; i++) begin : g_tmr
      localparam logic [7:0] A_LO = (i == 0) ? dtc_pkg::ADDR_T0_LO : dtc_pkg::ADDR_T1_LO;
      localparam logic [7:0] A_HI = (i == 0) ? dtc_pkg::ADDR_T0_HI : dtc_pkg::ADDR_T1_HI;
      localparam int B_TF = dtc_pkg::BIT_T0_OVF + i * dtc_pkg::CH_STRIDE;
      localparam int B_TR = dtc_pkg::BIT_T0_RUN + i * dtc_pkg::CH_STRIDE;
      localparam int B_IE = dtc_pkg::BIT_X0_FLAG + i * dtc_pkg::CH_STRIDE;
      localparam int B_IT = dtc_pkg::BIT_X0_TYPE + i * dtc_pkg::CH_STRIDE;

      assign sel_tick[i] = tm_r[i] ? tick_fast : tick_slow;
      assign src_evt[i] = tmode[i].ct ? pin_fall[i] : sel_tick[i];
      assign run_ok[i] = tr_r[i] && (!tmode[i].gate || pin_sync_r[EXT_BASE+i]);
      // Timer 1 freezes in mode 11
      if (i == 1) begin : g_hold
        assign inc[i] = run_ok[i] && src_evt[i] && (tmode[i].mode != dtc_pkg::MODE_SPLIT);
      end else begin : g_run
        assign inc[i] = run_ok[i] && src_evt[i];
      end
      assign cnt[i] = step(tmode[i].mode, tl_r[i], th_r[i], inc[i]);

      // With timer 0 split, its high byte owns the timer 1 flag
      if (i == 1) begin : g_ovf1
        assign ovf_set[i] = t0_split ? t0_hi_ovf : cnt[i].ovf;
      end else begin : g_ovf0
        assign ovf_set[i] = cnt[i].ovf;
      end

      // A software write to a count byte wins over a count in that cycle
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          tl_r[i] <= dtc_pkg::RST_COUNT;
        end else if (sfr_wr && sfr_addr == A_LO) begin
          tl_r[i] <= sfr_wdata;
        end else begin
          tl_r[i] <= cnt[i].lo;
        end
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          th_r[i] <= dtc_pkg::RST_COUNT;
        end else if (sfr_wr && sfr_addr == A_HI) begin
          th_r[i] <= sfr_wdata;
        end else if (i == 0 && t0_split) begin
          th_r[i] <= th_r[i] + (t0_hi_inc ? 8'h01 : 8'h00);
        end else begin
          th_r[i] <= cnt[i].hi;
        end
      end

      // Run and type bits are plain software state
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          tr_r[i] <= dtc_pkg::RST_TCTL[B_TR];
          it_r[i] <= dtc_pkg::RST_TCTL[B_IT];
        end else if (wr_tctl) begin
          tr_r[i] <= sfr_wdata[B_TR];
          it_r[i] <= sfr_wdata[B_IT];
        end
      end

      // Overflow flag: a hardware set beats an acknowledge or a write that clears
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          tf_r[i] <= dtc_pkg::RST_TCTL[B_TF];
        end else if (ovf_set[i]) begin
          tf_r[i] <= 1'b1;
        end else if (wr_tctl) begin
          tf_r[i] <= sfr_wdata[B_TF];
        end else if (vec_ack[i]) begin
          tf_r[i] <= 1'b0;
        end
      end

      // Detect flag: level mode mirrors the low pin, edge mode latches a fall
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          ie_r[i] <= dtc_pkg::RST_TCTL[B_IE];
        end else if (!it_r[i]) begin
          ie_r[i] <= !pin_sync_r[EXT_BASE+i];
        end else if (pin_fall[EXT_BASE+i]) begin
          ie_r[i] <= 1'b1;
        end else if (wr_tctl) begin
          ie_r[i] <= sfr_wdata[B_IE];
        end else if (ext_ack[i]) begin
          ie_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mode and clock-divide registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmode_r <= dtc_pkg::RST_TMODE;
    end else if (sfr_wr && sfr_addr == dtc_pkg::ADDR_TMODE) begin
      tmode_r <= sfr_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tm_r <= dtc_pkg::RST_DIVSEL;
    end else if (sfr_wr && sfr_addr == dtc_pkg::ADDR_CLKCTL) begin
      tm_r <= sfr_wdata[dtc_pkg::BIT_T0_DIV+1:dtc_pkg::BIT_T0_DIV];
    end
  end

  // Read path
  always_comb begin
    rdata_nxt = dtc_pkg::UNIMPL_READ;
    unique case (sfr_addr)
      dtc_pkg::ADDR_TCTL: rdata_nxt = {tf_r[1], tr_r[1], tf_r[0], tr_r[0], ie_r[1], it_r[1], ie_r[0], it_r[0]};
      dtc_pkg::ADDR_TMODE: rdata_nxt = tmode_r;
      dtc_pkg::ADDR_T0_LO: rdata_nxt = tl_r[0];
      dtc_pkg::ADDR_T1_LO: rdata_nxt = tl_r[1];
      dtc_pkg::ADDR_T0_HI: rdata_nxt = th_r[0];
      dtc_pkg::ADDR_T1_HI: rdata_nxt = th_r[1];
      dtc_pkg::ADDR_CLKCTL: begin
        // Only the two timer divide bits live here; the rest read high
        rdata_nxt[dtc_pkg::BIT_T0_DIV+1:dtc_pkg::BIT_T0_DIV] = tm_r;
      end
      default: rdata_nxt = dtc_pkg::UNIMPL_READ;
    endcase
  end

  // Read data is captured on the strobe and held until the next read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= dtc_pkg::RST_RDATA;
    end else if (sfr_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign t0_overflow_flag = tf_r[0];
  assign t1_overflow_flag = tf_r[1];
  assign ext_ext_pin_a_detect_flag = ie_r[0];
  assign ext_ext_pin_b_detect_flag = ie_r[1];

endmodule
